// [core/mvof_defines.vh]
// Constants for the measured value output framer: map, fields, resets, chars
`ifndef MVOF_DEFINES_VH
`define MVOF_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MVOF_CTRL_OFS 8'h00
`define MVOF_SER_OFS 8'h04
`define MVOF_STAT_OFS 8'h08
`define MVOF_ENT_BASE 2'b01
`define MVOF_ENT_DESC 2'h0
`define MVOF_ENT_INT 2'h1
`define MVOF_ENT_FRAC 2'h2

// ****************************************************************
// Control register fields
// ****************************************************************
`define MVOF_C_DTG 0
`define MVOF_C_INCH 1
`define MVOF_C_DIA 2
`define MVOF_C_DMS 3
`define MVOF_C_LF 4
`define MVOF_C_PRINT 5
`define MVOF_C_HS 6
`define MVOF_C_PKIND 9:8
`define MVOF_C_PAXIS 11:10
`define MVOF_C_AXEN 15:12
`define MVOF_C_TAIL 19:16
`define MVOF_CTRL_RST 20'h0F030

// ****************************************************************
// Serial framing register fields
// ****************************************************************
`define MVOF_S_BAUD 3:0
`define MVOF_S_DATA8 4
`define MVOF_S_PAR 6:5
`define MVOF_S_STOP2 7
`define MVOF_SER_RST 8'h14

// ****************************************************************
// Entry descriptor fields
// ****************************************************************
`define MVOF_D_LETTER 7:0
`define MVOF_D_NEG 8
`define MVOF_D_ICNT 12:9
`define MVOF_D_FCNT 15:13
`define MVOF_D_ROT 16
`define MVOF_D_SCNT 18:17

// ****************************************************************
// Status register fields
// ****************************************************************
`define MVOF_ST_MISS 16

// ****************************************************************
// Characters
// ****************************************************************
`define MVOF_CH_CR 8'h0D
`define MVOF_CH_LF 8'h0A
`define MVOF_CH_SP 8'h20
`define MVOF_CH_QUOTE 8'h22
`define MVOF_CH_PLUS 8'h2B
`define MVOF_CH_MINUS 8'h2D
`define MVOF_CH_DOT 8'h2E
`define MVOF_CH_COLON 8'h3A
`define MVOF_CH_EQ 8'h3D
`define MVOF_CH_CTRLB 8'h02
`define MVOF_CH_A 8'h41
`define MVOF_CH_C 8'h43
`define MVOF_CH_D 8'h44
`define MVOF_CH_I 8'h49
`define MVOF_CH_L 8'h4C
`define MVOF_CH_R 8'h52
`define MVOF_CH_S 8'h53
`define MVOF_CH_T 8'h54
`define MVOF_CH_W 8'h57

`endif

// [core/mvof_trig.v]
// Start trigger detection: remote switch, received Ctrl B, edge finder
`timescale 1ns/1ps
`include "mvof_defines.vh"

module mvof_trig (
  input wire ref_clk,
  input wire rst_b,
  input wire remote_sw_n,
  input wire probe_sw,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire print_en,
  output reg disp_go_q,
  output reg probe_go_q
);

  reg remote_prev_q;
  reg probe_prev_q;

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  // Previous levels reset to the idle state so no false start at release
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remote_prev_q <= 1'b1;
      probe_prev_q <= 1'b0;
      disp_go_q <= 1'b0;
      probe_go_q <= 1'b0;
    end else begin
      remote_prev_q <= remote_sw_n;
      probe_prev_q <= probe_sw;
      disp_go_q <= (remote_prev_q & ~remote_sw_n) |
        (rx_valid & (rx_data == `MVOF_CH_CTRLB));
      probe_go_q <= ~probe_prev_q & probe_sw & print_en;
    end
  end

endmodule // mvof_trig

// [core/mvof_framer.v]
// Measured value output framer: formats axis and probe records as ASCII
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "mvof_defines.vh"

module mvof_framer #(
  parameter NUM_ENT = 4
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire remote_sw_n,
  input wire probe_sw,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  input wire cts,
  output reg rts,
  output reg dtr,
  output wire [3:0] baud_sel,
  output wire data_8bit,
  output wire [1:0] parity_sel,
  output wire stop_2bit,
  output wire busy
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam S_IDLE = 4'h0;
  localparam S_PICK = 4'h1;
  localparam S_PRE = 4'h2;
  localparam S_SIGN = 4'h3;
  localparam S_INT = 4'h4;
  localparam S_SEP1 = 4'h5;
  localparam S_FRAC = 4'h6;
  localparam S_SEP2 = 4'h7;
  localparam S_SEC = 4'h8;
  localparam S_UNIT = 4'h9;
  localparam S_SUF = 4'hA;
  localparam S_CR = 4'hB;
  localparam S_LF = 4'hC;
  localparam S_TAIL = 4'hD;

  localparam PK_EDGE = 2'h0;
  localparam PK_CLINE = 2'h1;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [19:0] ctrl_q;
  reg [7:0] ser_q;
  reg [18:0] desc_q [0:NUM_ENT-1];
  reg [31:0] int_q [0:NUM_ENT-1];
  reg [23:0] frac_q [0:NUM_ENT-1];
  reg miss_q;
  reg [7:0] done_cnt_q;
  reg [3:0] st_q;
  reg [3:0] st_d;
  reg [3:0] idx_q;
  reg [3:0] idx_d;
  reg [2:0] rec_q;
  reg [2:0] rec_d;
  reg [3:0] tail_q;
  reg [3:0] tail_d;
  reg probe_job_q;
  reg [7:0] ch;
  reg emit;
  integer i;

  wire disp_go;
  wire probe_go;
  wire go;
  wire reg_hit;
  wire [1:0] ent_w;
  wire [1:0] sub_w;
  wire [1:0] pkind;
  wire [1:0] ent;
  wire [18:0] cur_desc;
  wire [31:0] cur_int;
  wire [23:0] cur_frac;
  wire is_rot;
  wire is_dms;
  wire is_lbl;
  wire blank_pos;
  wire [3:0] icnt;
  wire [3:0] fcnt;
  wire [3:0] scnt;
  wire [3:0] plen;
  wire cts_ok;
  wire rec_ok;
  wire [3:0] idx_inc;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function [7:0] digit_char;
    input [3:0] nib;
    begin
      digit_char = {4'h3, nib};
    end
  endfunction

  function [3:0] nibble;
    input [31:0] word;
    input [2:0] pos;
    begin
      nibble = word[{pos, 2'b00} +: 4];
    end
  endfunction

  // Third char of CC and CL labels comes from the entry letter, so the plane sets it; DST and DIA are fixed
  function [7:0] label_char;
    input [1:0] kind;
    input [1:0] rec;
    input [1:0] pos;
    input [7:0] letter;
    begin
      label_char = `MVOF_CH_COLON;
      if (kind == PK_CLINE) begin
        if (rec == 2'h0) begin
          label_char = (pos == 2'h0) ? `MVOF_CH_D :
            (pos == 2'h1) ? `MVOF_CH_S :
            (pos == 2'h2) ? `MVOF_CH_T : `MVOF_CH_COLON;
        end else begin
          label_char = (pos == 2'h0) ? `MVOF_CH_C :
            (pos == 2'h1) ? `MVOF_CH_L :
            (pos == 2'h2) ? letter : `MVOF_CH_COLON;
        end
      end else if (rec == 2'h2) begin
        label_char = (pos == 2'h0) ? `MVOF_CH_D :
          (pos == 2'h1) ? `MVOF_CH_I :
          (pos == 2'h2) ? `MVOF_CH_A : `MVOF_CH_COLON;
      end else begin
        label_char = (pos == 2'h0) ? `MVOF_CH_C :
          (pos == 2'h1) ? `MVOF_CH_C :
          (pos == 2'h2) ? letter : `MVOF_CH_COLON;
      end
    end
  endfunction

  // ****************************************************************
  // Triggers
  // ****************************************************************
  mvof_trig u_trig (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .remote_sw_n(remote_sw_n),
    .probe_sw(probe_sw),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .print_en(ctrl_q[`MVOF_C_PRINT]),
    .disp_go_q(disp_go),
    .probe_go_q(probe_go)
  );

  assign go = disp_go | probe_go;
  assign busy = (st_q != S_IDLE);

  // ****************************************************************
  // Register port
  // ****************************************************************
  assign ent_w = addr[5:4];
  assign sub_w = addr[3:2];
  assign reg_hit = (addr[7:6] == `MVOF_ENT_BASE) && (addr[1:0] == 2'b00);

  assign baud_sel = ser_q[`MVOF_S_BAUD];
  assign data_8bit = ser_q[`MVOF_S_DATA8];
  assign parity_sel = ser_q[`MVOF_S_PAR];
  assign stop_2bit = ser_q[`MVOF_S_STOP2];

  // Values are read live while sending; software should not rewrite
  // an entry while busy is high
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `MVOF_CTRL_RST;
      ser_q <= `MVOF_SER_RST;
      miss_q <= 1'b0;
      rdata <= 32'h0000_0000;
      for (i = 0; i < NUM_ENT; i = i + 1) begin
        desc_q[i] <= 19'h0_0200;
        int_q[i] <= 32'h0000_0000;
        frac_q[i] <= 24'h00_0000;
      end
    end else begin
      if (wr_stb && addr == `MVOF_CTRL_OFS) begin
        ctrl_q <= wdata[19:0];
      end
      if (wr_stb && addr == `MVOF_SER_OFS) begin
        ser_q <= wdata[7:0];
      end
      if (wr_stb && reg_hit) begin
        case (sub_w)
          `MVOF_ENT_DESC: desc_q[ent_w] <= wdata[18:0];
          `MVOF_ENT_INT: int_q[ent_w] <= wdata;
          `MVOF_ENT_FRAC: frac_q[ent_w] <= wdata[23:0];
          default: ;
        endcase
      end
      // A trigger lost while busy wins over a clear in the same cycle
      if (go && busy) begin
        miss_q <= 1'b1;
      end else if (wr_stb && addr == `MVOF_STAT_OFS &&
                   wdata[`MVOF_ST_MISS]) begin
        miss_q <= 1'b0;
      end
      rdata <= 32'h0000_0000;
      if (rd_stb) begin
        if (addr == `MVOF_CTRL_OFS) begin
          rdata <= {12'h000, ctrl_q};
        end else if (addr == `MVOF_SER_OFS) begin
          rdata <= {24'h00_0000, ser_q};
        end else if (addr == `MVOF_STAT_OFS) begin
          rdata <= {done_cnt_q, 7'h00, miss_q, 8'h00, st_q,
                    rec_q, probe_job_q};
        end else if (reg_hit) begin
          case (sub_w)
            `MVOF_ENT_DESC: rdata <= {13'h0000, desc_q[ent_w]};
            `MVOF_ENT_INT: rdata <= int_q[ent_w];
            `MVOF_ENT_FRAC: rdata <= {8'h00, frac_q[ent_w]};
            default: rdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Record selection
  // ****************************************************************
  assign pkind = ctrl_q[`MVOF_C_PKIND];
  assign ent = (probe_job_q && pkind == PK_EDGE) ?
    ctrl_q[`MVOF_C_PAXIS] : rec_q[1:0];
  assign cur_desc = desc_q[ent];
  assign cur_int = int_q[ent];
  assign cur_frac = frac_q[ent];
  assign is_rot = !probe_job_q && cur_desc[`MVOF_D_ROT];
  assign is_dms = is_rot && ctrl_q[`MVOF_C_DMS];
  assign is_lbl = probe_job_q && pkind != PK_EDGE;
  // Edge, distance and diameter show a blank for a positive value
  assign blank_pos = probe_job_q && (pkind == PK_EDGE ||
    (pkind == PK_CLINE ? rec_q[1:0] == 2'h0 : rec_q[1:0] == 2'h2));
  assign icnt = (cur_desc[`MVOF_D_ICNT] == 4'h0) ? 4'h1 :
    cur_desc[`MVOF_D_ICNT];
  assign fcnt = {1'b0, cur_desc[`MVOF_D_FCNT]};
  assign scnt = {2'b00, cur_desc[`MVOF_D_SCNT]};
  assign plen = probe_job_q ? 4'h4 : 4'h2;
  assign cts_ok = !ctrl_q[`MVOF_C_HS] || cts;
  assign idx_inc = idx_q + 4'h1;
  // Display uses the axis mask; probe kinds have one, two or three
  assign rec_ok = !rec_q[2] && (probe_job_q ?
    (pkind == PK_EDGE ? rec_q[1:0] == 2'h0 :
     pkind == PK_CLINE ? rec_q[1:0] != 2'h2 && rec_q[1:0] != 2'h3 :
     rec_q[1:0] != 2'h3) :
    ctrl_q[12 + rec_q[1:0]]);

  // ****************************************************************
  // Character sequencer
  // ****************************************************************
  always @* begin
    st_d = st_q;
    idx_d = idx_q;
    rec_d = rec_q;
    tail_d = tail_q;
    ch = `MVOF_CH_SP;
    emit = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (go) begin
          st_d = S_PICK;
          rec_d = 3'h0;
          tail_d = ctrl_q[`MVOF_C_TAIL];
        end
      end
      S_PICK: begin
        idx_d = 4'h0;
        if (rec_q[2]) begin
          st_d = (tail_q == 4'h0) ? S_IDLE : S_TAIL;
        end else if (rec_ok) begin
          st_d = S_PRE;
        end else begin
          rec_d = rec_q + 3'h1;
        end
      end
      S_PRE: begin
        emit = 1'b1;
        if (is_lbl) begin
          ch = label_char(pkind, rec_q[1:0], idx_q[1:0],
                          cur_desc[`MVOF_D_LETTER]);
        end else if (idx_q == 4'h0) begin
          ch = cur_desc[`MVOF_D_LETTER];
        end else if (probe_job_q) begin
          ch = (idx_q == 4'h3) ? `MVOF_CH_COLON : `MVOF_CH_SP;
        end else begin
          ch = `MVOF_CH_EQ;
        end
        idx_d = idx_inc;
        if (idx_inc == plen) begin
          st_d = S_SIGN;
        end
      end
      S_SIGN: begin
        emit = 1'b1;
        ch = cur_desc[`MVOF_D_NEG] ? `MVOF_CH_MINUS :
          blank_pos ? `MVOF_CH_SP : `MVOF_CH_PLUS;
        idx_d = icnt - 4'h1;
        st_d = S_INT;
      end
      S_INT: begin
        emit = 1'b1;
        ch = digit_char(nibble(cur_int, idx_q[2:0]));
        idx_d = idx_q - 4'h1;
        if (idx_q == 4'h0) begin
          st_d = S_SEP1;
        end
      end
      S_SEP1: begin
        emit = 1'b1;
        ch = is_dms ? `MVOF_CH_COLON : `MVOF_CH_DOT;
        idx_d = 4'h0;
        if (fcnt != 4'h0) begin
          st_d = S_FRAC;
        end else begin
          st_d = is_dms ? S_SEP2 : S_UNIT;
        end
      end
      S_FRAC: begin
        emit = 1'b1;
        ch = digit_char(nibble({8'h00, cur_frac},
                               3'h5 - idx_q[2:0]));
        idx_d = idx_inc;
        if (idx_inc == fcnt) begin
          st_d = is_dms ? S_SEP2 : S_UNIT;
        end
      end
      S_SEP2: begin
        emit = 1'b1;
        ch = `MVOF_CH_COLON;
        idx_d = 4'h0;
        st_d = (scnt == 4'h0) ? S_UNIT : S_SEC;
      end
      S_SEC: begin
        emit = 1'b1;
        ch = digit_char(nibble({8'h00, cur_frac},
                               3'h3 - idx_q[2:0]));
        idx_d = idx_inc;
        if (idx_inc == scnt) begin
          st_d = S_UNIT;
        end
      end
      S_UNIT: begin
        emit = 1'b1;
        ch = (!is_rot && ctrl_q[`MVOF_C_INCH]) ?
          `MVOF_CH_QUOTE : `MVOF_CH_SP;
        st_d = S_SUF;
      end
      S_SUF: begin
        emit = 1'b1;
        if (is_rot) begin
          ch = ctrl_q[`MVOF_C_DTG] ? 8'h77 : `MVOF_CH_W;
        end else begin
          ch = ctrl_q[`MVOF_C_DIA] ? `MVOF_CH_D : `MVOF_CH_R;
          if (!probe_job_q && ctrl_q[`MVOF_C_DTG]) begin
            ch = ch | 8'h20;
          end
        end
        st_d = S_CR;
      end
      S_CR: begin
        emit = 1'b1;
        ch = `MVOF_CH_CR;
        if (ctrl_q[`MVOF_C_LF]) begin
          st_d = S_LF;
        end else begin
          st_d = S_PICK;
          rec_d = rec_q + 3'h1;
        end
      end
      S_LF: begin
        emit = 1'b1;
        ch = `MVOF_CH_LF;
        st_d = S_PICK;
        rec_d = rec_q + 3'h1;
      end
      S_TAIL: begin
        emit = 1'b1;
        ch = `MVOF_CH_CR;
        tail_d = tail_q - 4'h1;
        if (tail_q == 4'h1) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer state and transmit holding register
  // ****************************************************************
  // One char is held until taken; the sequencer stalls meanwhile, so
  // a slow line or a deasserted clear to send only delays output
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      idx_q <= 4'h0;
      rec_q <= 3'h0;
      tail_q <= 4'h0;
      probe_job_q <= 1'b0;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      rts <= 1'b0;
      dtr <= 1'b0;
      done_cnt_q <= 8'h00;
    end else begin
      dtr <= 1'b1;
      rts <= busy | tx_valid;
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
      end
      if (st_q == S_IDLE && go) begin
        probe_job_q <= !disp_go;
      end
      if (!emit || (!tx_valid && cts_ok)) begin
        st_q <= st_d;
        idx_q <= idx_d;
        rec_q <= rec_d;
        tail_q <= tail_d;
        if (emit) begin
          tx_data <= ch;
          tx_valid <= 1'b1;
        end
        if (busy && st_d == S_IDLE) begin
          done_cnt_q <= done_cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // mvof_framer

// [verif/mvof_props.sv]
// Checker of the framer top ports: character stream, triggers, settings
`timescale 1ns/1ps
`include "mvof_defines.vh"

module mvof_props (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire remote_sw_n,
  input wire probe_sw,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire cts,
  input wire dtr,
  input wire [3:0] baud_sel,
  input wire data_8bit,
  input wire [1:0] parity_sel,
  input wire stop_2bit,
  input wire busy
);
  // ********
  // Shadow settings
  // ********
  reg [19:0] ctl_q;
  reg [7:0] ser_q;
  wire go_ok;
  // Tracked from bus writes, so a write the design drops is caught
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= `MVOF_CTRL_RST;
      ser_q <= `MVOF_SER_RST;
    end else if (wr_stb) begin
      if (addr == `MVOF_CTRL_OFS)
        ctl_q <= wdata[19:0];
      if (addr == `MVOF_SER_OFS)
        ser_q <= wdata[7:0];
    end
  end
  assign go_ok = !ctl_q[`MVOF_C_HS] || cts;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ********
  // Properties
  // ********
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held character changed before acceptance");
  property p_remote;
    $fell(remote_sw_n) && !busy && go_ok |-> ##[2:4] tx_valid;
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote switch did not start output");
  property p_ctrlb;
    rx_valid && rx_data == `MVOF_CH_CTRLB && !busy && go_ok
      |-> ##[2:4] tx_valid;
  endproperty
  a_ctrlb: assert property (p_ctrlb)
    else $error("received start character did not start output");
  property p_probe_off;
    $rose(probe_sw) && !ctl_q[`MVOF_C_PRINT] && !busy |=> !busy [*4];
  endproperty
  a_probe_off: assert property (p_probe_off)
    else $error("probe output started while printing is off");
  property p_cts;
    ctl_q[`MVOF_C_HS] && !cts && !tx_valid |=> !tx_valid;
  endproperty
  a_cts: assert property (p_cts)
    else $error("character loaded while clear to send is low");
  property p_dtr;
    $past(rst_b) |-> dtr;
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("terminal ready low after reset");
  property p_lf;
    tx_valid && !ctl_q[`MVOF_C_LF] |-> tx_data != `MVOF_CH_LF;
  endproperty
  a_lf: assert property (p_lf)
    else $error("line feed sent while disabled");
  property p_baud;
    baud_sel == ser_q[3:0];
  endproperty
  a_baud: assert property (p_baud)
    else $error("rate select differs from written setting");
  property p_frame;
    {stop_2bit, parity_sel, data_8bit} == ser_q[7:4];
  endproperty
  a_frame: assert property (p_frame)
    else $error("framing outputs differ from written setting");
endmodule // mvof_props

// [verif/mvof_term.sv]
// Terminal model that takes characters from the framer
`timescale 1ns/1ps

module mvof_term (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire slow,
  output reg tx_ready
);
  logic [7:0] q[$];
  reg [1:0] cnt_q;
  // Slow mode stalls two cycles in four so held characters are exercised
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready <= !slow || cnt_q[1];
      // Whole characters, taken in a cycle where valid and ready are both high
      if (tx_valid && tx_ready)
        q.push_back(tx_data);
    end
  end
endmodule // mvof_term

// [verif/testbench.sv]
// Self-checking testbench for the measured value output framer
`timescale 1ns/1ps
`include "mvof_defines.vh"
`define CHK(g, e) begin \
  tests_run = tests_run + 1; \
  if ((g) !== (e)) begin \
    fails = fails + 1; \
    $display("mismatch %0t %h %h", $time, (g), (e)); \
  end \
end

module testbench;
  reg ref_clk, rst_b, wr_stb, rd_stb, remote_sw_n, probe_sw, rx_valid;
  reg cts, slow;
  reg [7:0] addr, rx_data;
  reg [31:0] wdata, d;
  wire [31:0] rdata;
  wire [7:0] tx_data;
  wire [3:0] baud_sel;
  wire [1:0] parity_sel;
  wire tx_valid, tx_ready, rts, dtr, data_8bit, stop_2bit, busy;
  integer fails, tests_run, tn;

  mvof_framer #(.NUM_ENT(4)) dut (.ref_clk, .rst_b, .addr, .wdata, .wr_stb,
    .rd_stb, .rdata, .remote_sw_n, .probe_sw, .rx_valid, .rx_data, .tx_data,
    .tx_valid, .tx_ready, .cts, .rts, .dtr, .baud_sel, .data_8bit,
    .parity_sel, .stop_2bit, .busy);
  mvof_term term (.ref_clk, .rst_b, .tx_data, .tx_valid, .slow, .tx_ready);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function [31:0] dsc(input [7:0] l, input n, input [3:0] ic,
    input [2:0] fc, input r, input [1:0] sc);
    dsc = {13'h0, sc, r, fc, ic, n, l};
  endfunction

  task wr(input [7:0] a, input [31:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task rd(input [7:0] a, output [31:0] v);
    begin
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1;
      v = rdata;
      @(posedge ref_clk);
    end
  endtask

  task ent(input [1:0] e, input [31:0] ds, input [31:0] iv, input [31:0] fv);
    begin
      wr({`MVOF_ENT_BASE, e, `MVOF_ENT_DESC, 2'h0}, ds);
      wr({`MVOF_ENT_BASE, e, `MVOF_ENT_INT, 2'h0}, iv);
      wr({`MVOF_ENT_BASE, e, `MVOF_ENT_FRAC, 2'h0}, fv);
    end
  endtask

  // Kind 0 remote switch, 1 received start character, 2 edge finder
  task fire(input integer k);
    begin
      remote_sw_n <= (k != 0);
      rx_valid <= (k == 1);
      probe_sw <= (k == 2);
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      @(posedge ref_clk);
      remote_sw_n <= 1'b1;
      probe_sw <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task tend;
    begin
      tn = tn + 1;
      $display("test %0d ended", tn);
    end
  endtask

  task run(input string e);
    integer i;
    begin
      for (i = 0; i < 3000 && (i < 8 || busy !== 1'b0 ||
          tx_valid !== 1'b0); i = i + 1) begin
        @(posedge ref_clk);
        #1;
      end
      @(posedge ref_clk);
      `CHK(i < 3000, 1'b1)
      if (i == 3000)
        test_done;
      `CHK(term.q.size(), e.len())
      for (i = 0; i < e.len() && i < term.q.size(); i = i + 1)
        `CHK(term.q[i], e[i])
      term.q.delete();
      tend;
    end
  endtask

  task test_done;
    begin
      $display("counts %0d compares %0d mismatches", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  initial begin
    {wr_stb, rd_stb, probe_sw, rx_valid, slow, rst_b} = 6'h0;
    {remote_sw_n, cts} = 2'h3;
    {addr, wdata} = 40'h0;
    rx_data = `MVOF_CH_CTRLB;
    fails = 0;
    tests_run = 0;
    tn = 0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(`MVOF_CTRL_OFS, d);
    `CHK(d, {12'h0, `MVOF_CTRL_RST})
    rd(`MVOF_SER_OFS, d);
    `CHK(d, {24'h0, `MVOF_SER_RST})
    `CHK({stop_2bit, parity_sel, data_8bit, baud_sel}, `MVOF_SER_RST)
    wr(`MVOF_SER_OFS, 32'hFFFFFFC8);
    rd(`MVOF_SER_OFS, d);
    `CHK(d, 32'h000000C8)
    `CHK({stop_2bit, parity_sel, data_8bit, baud_sel}, 8'hC8)
    rd({`MVOF_ENT_BASE, 2'h0, `MVOF_ENT_DESC, 2'h0}, d);
    `CHK(d, 32'h00000200)
    wr(8'hF0, 32'hFFFFFFFF);
    rd(8'hF0, d);
    `CHK(d, 32'h0)
    tend;
    ent(2'h0, dsc("X", 1'b0, 4'h2, 3'h2, 1'b0, 2'h0), 32'h41, 32'h290000);
    wr(`MVOF_CTRL_OFS, 32'h01010);
    fire(0);
    run("X=+41.29 R\r\n");
    slow <= 1'b1;
    ent(2'h0, dsc("X", 1'b1, 4'h7, 3'h6, 1'b0, 2'h0), 32'h1234567, 32'h123456);
    wr(`MVOF_CTRL_OFS, 32'h91007);
    fire(1);
    run("X=-1234567.123456\"d\r\r\r\r\r\r\r\r\r\r");
    slow <= 1'b0;
    ent(2'h0, dsc("X", 1'b0, 4'h2, 3'h1, 1'b0, 2'h0), 32'h41, 32'h200000);
    ent(2'h1, dsc(`MVOF_CH_C, 1'b0, 4'h4, 3'h4, 1'b1, 2'h0), 32'h1260, 32'h0);
    wr(`MVOF_CTRL_OFS, 32'h03011);
    fire(0);
    run("X=+41.2 r\r\nC=+1260.0000 w\r\n");
    ent(2'h1, dsc(`MVOF_CH_C, 1'b0, 4'h3, 3'h2, 1'b1, 2'h2), 32'h360, 32'h234500);
    wr(`MVOF_CTRL_OFS, 32'h02058);
    cts <= 1'b0;
    fire(1);
    repeat (10) @(posedge ref_clk);
    cts <= 1'b1;
    #1;
    `CHK(tx_valid, 1'b0)
    `CHK(rts, 1'b1)
    run("C=+360:23:45 W\r\n");
    ent(2'h1, dsc("Y", 1'b1, 4'h4, 3'h4, 1'b0, 2'h0), 32'h3674, 32'h449800);
    wr(`MVOF_CTRL_OFS, 32'h0F430);
    fire(2);
    run("Y  :-3674.4498 R\r\n");
    wr(`MVOF_CTRL_OFS, 32'h0F410);
    fire(2);
    run("");
    ent(2'h0, dsc("X", 1'b1, 4'h4, 3'h4, 1'b0, 2'h0), 32'h1616, 32'h342900);
    ent(2'h1, dsc("Y", 1'b0, 4'h4, 3'h4, 1'b0, 2'h0), 32'h4362, 32'h987600);
    ent(2'h2, dsc(`MVOF_CH_D, 1'b0, 4'h4, 3'h4, 1'b0, 2'h0), 32'h1250,
      32'h050000);
    wr(`MVOF_CTRL_OFS, 32'h0F230);
    fire(2);
    run({"CCX:-1616.3429 R\r\nCCY:+4362.9876 R\r\n",
      "DIA: 1250.0500 R\r\n"});
    wr(`MVOF_CTRL_OFS, 32'h0F130);
    fire(2);
    run("DST:-1616.3429 R\r\nCLY:+4362.9876 R\r\n");
    // A second start while busy must not restart or splice records
    wr(`MVOF_CTRL_OFS, 32'h01010);
    fire(0);
    fire(1);
    run("X=-1616.3429 R\r\n");
    rd(`MVOF_STAT_OFS, d);
    `CHK(d[`MVOF_ST_MISS], 1'b1)
    `CHK(d[31:24], 8'h08)
    wr(`MVOF_STAT_OFS, 32'h00010000);
    rd(`MVOF_STAT_OFS, d);
    `CHK(d[`MVOF_ST_MISS], 1'b0)
    tend;
    wr(`MVOF_CTRL_OFS, 32'h0F430);
    fire(2);
    run("Y  : 4362.9876 R\r\n");
    test_done;
  end
endmodule // testbench

bind mvof_framer mvof_props u_props (.ref_clk, .rst_b, .addr, .wdata, .wr_stb,
  .remote_sw_n, .probe_sw, .rx_valid, .rx_data, .tx_data, .tx_valid,
  .tx_ready, .cts, .dtr, .baud_sel, .data_8bit, .parity_sel, .stop_2bit,
  .busy);
